// file: hw/gpio_port_regs.vh
// constants for the seven-pin general purpose port block
// assumes inclusion by bare name from the design files under hw/
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define GPIO_ADDR_W        12
`define GPIO_DATA_W        32
`define GPIO_IDX_LSB       2
`define GPIO_IDX_MSB       11
`define GPIO_IDX_W         10

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define GPIO_IDX_A_DATA    10'h000
`define GPIO_IDX_A_PULL    10'h001
`define GPIO_IDX_A_DIR     10'h003
`define GPIO_IDX_B_DATA    10'h004
`define GPIO_IDX_B_PULL    10'h005
`define GPIO_IDX_B_DIR     10'h007

// ----------------------------------------------------------------
// field widths and pin positions
// ----------------------------------------------------------------
`define GPIO_PIN_W         7
`define GPIO_A_W           5
`define GPIO_A_PULL_W      4
`define GPIO_B_W           2
`define GPIO_A_MSB         4
`define GPIO_A_PULL_MSB    3
`define GPIO_B_LSB         5
`define GPIO_B_MSB         6
`define GPIO_B_FLD_MSB     1

// ----------------------------------------------------------------
// reset values and responses
// ----------------------------------------------------------------
`define GPIO_A_RST         5'h00
`define GPIO_A_PULL_RST    4'h0
`define GPIO_B_RST         2'h0
`define GPIO_PIN_RST       7'h00
`define GPIO_WORD_RST      32'h00000000
`define GPIO_ADDR_RST      12'h000
`define GPIO_STRB_RST      4'h0
`define AXI_RESP_OKAY      2'h0
`define AXI_RESP_SLVERR    2'h2

`endif

// file: hw/pin_level_sync.v
// three-stage synchroniser for asynchronous pin levels
// assumes pins change freely relative to the bus clock
`timescale 1ns/100ps

module pin_level_sync #(
	parameter WIDTH = 7
) (
	// clock and reset
	input  wire             aclk,
	input  wire             aresetn,
	// raw and settled levels
	input  wire [WIDTH-1:0] raw_in,
	output reg  [WIDTH-1:0] level_out
);

	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;
	reg [WIDTH-1:0] stage3_reg;

	// ----------------------------------------------------------------
	// stages; a change counts once stages two and three agree
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
			stage3_reg <= {WIDTH{1'b0}};
			level_out  <= {WIDTH{1'b0}};
		end else begin
			stage1_reg <= raw_in;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			// per bit: a lone mismatch is held off one more cycle
			level_out  <= (stage2_reg & stage3_reg) |
				(level_out & (stage2_reg ^ stage3_reg));
		end
	end

endmodule

// file: hw/gpio_port_pin_control.v
// seven-pin general purpose port: data, direction, pullup control
// assumes an AXI4-Lite master, pads outside, and shared peripherals
// that present their own enable, drive and output-enable per pin
//
// Notes on behaviour
// - five-pin port A, two-pin port B
// - direction enables driver and selects read source
// - input buffer on unless analog function or deep stop
// - digital function drives buffer, direction selects read
// - analog function disables input and output buffers
// - input pin with buffer off reads zero
// - analog wins over digital on same pin
// - pull-enable bit switches pullup on
// - pullup off whenever pin drives, any source
// - pullup off under analog function
// - deep stop clears registers, pins fully off
// - light stop keeps pins and registers
// - port A read: pin level or latched value
// - writes latch all bits, outputs drive latch
// - reset clears data, pins high-impedance inputs
// - port A pull bits 3:0, reset zero
// - enabled peripheral overrides port; off after reset
`timescale 1ns/100ps

`include "gpio_port_regs.vh"

module gpio_port_pin_control (
	// clock and reset
	input  wire                      aclk,
	input  wire                      aresetn,
	// write address channel
	input  wire [`GPIO_ADDR_W-1:0]   s_axi_awaddr,
	input  wire                      s_axi_awvalid,
	output wire                      s_axi_awready,
	// write data channel
	input  wire [`GPIO_DATA_W-1:0]   s_axi_wdata,
	input  wire [3:0]                s_axi_wstrb,
	input  wire                      s_axi_wvalid,
	output wire                      s_axi_wready,
	// write response channel
	output reg  [1:0]                s_axi_bresp,
	output reg                       s_axi_bvalid,
	input  wire                      s_axi_bready,
	// read address channel
	input  wire [`GPIO_ADDR_W-1:0]   s_axi_araddr,
	input  wire                      s_axi_arvalid,
	output wire                      s_axi_arready,
	// read data channel
	output reg  [`GPIO_DATA_W-1:0]   s_axi_rdata,
	output reg  [1:0]                s_axi_rresp,
	output reg                       s_axi_rvalid,
	input  wire                      s_axi_rready,
	// pads, bits 4:0 port A, bits 6:5 port B
	input  wire [`GPIO_PIN_W-1:0]    pin_in,
	output reg  [`GPIO_PIN_W-1:0]    pin_out,
	output reg  [`GPIO_PIN_W-1:0]    pin_oe,
	output reg  [`GPIO_PIN_W-1:0]    pin_ie,
	output reg  [`GPIO_PIN_W-1:0]    pin_pullup_en,
	// shared peripheral functions
	input  wire [`GPIO_PIN_W-1:0]    alt_digital_en,
	input  wire [`GPIO_PIN_W-1:0]    alt_digital_oe,
	input  wire [`GPIO_PIN_W-1:0]    alt_digital_out,
	input  wire [`GPIO_PIN_W-1:0]    alt_analog_en,
	// power modes
	input  wire                      deep_stop_mode,
	input  wire                      light_stop_mode
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function mapped_index;
		input [`GPIO_ADDR_W-1:0] addr;
		reg   [`GPIO_IDX_W-1:0]  idx;
		begin
			idx = addr[`GPIO_IDX_MSB:`GPIO_IDX_LSB];
			mapped_index = (idx == `GPIO_IDX_A_DATA) || (idx == `GPIO_IDX_A_PULL) ||
				(idx == `GPIO_IDX_A_DIR) || (idx == `GPIO_IDX_B_DATA) ||
				(idx == `GPIO_IDX_B_PULL) || (idx == `GPIO_IDX_B_DIR);
		end
	endfunction

	// data bit read: latch for outputs, settled pin for enabled inputs
	function [`GPIO_PIN_W-1:0] port_read;
		input [`GPIO_PIN_W-1:0] latched;
		input [`GPIO_PIN_W-1:0] dir;
		input [`GPIO_PIN_W-1:0] in_buf_on;
		input [`GPIO_PIN_W-1:0] level;
		begin
			port_read = (dir & latched) | (~dir & in_buf_on & level);
		end
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg  [`GPIO_A_W-1:0]      a_data_reg;
	reg  [`GPIO_A_PULL_W-1:0] a_pull_reg;
	reg  [`GPIO_A_W-1:0]      a_dir_reg;
	reg  [`GPIO_B_W-1:0]      b_data_reg;
	reg  [`GPIO_B_W-1:0]      b_pull_reg;
	reg  [`GPIO_B_W-1:0]      b_dir_reg;

	reg                       aw_held_reg;
	reg  [`GPIO_ADDR_W-1:0]   aw_addr_reg;
	reg                       w_held_reg;
	reg  [`GPIO_DATA_W-1:0]   w_data_reg;
	reg  [3:0]                w_strb_reg;

	wire [`GPIO_PIN_W-1:0]    pin_level;
	wire [`GPIO_PIN_W-1:0]    data_all;
	wire [`GPIO_PIN_W-1:0]    dir_all;
	wire [`GPIO_PIN_W-1:0]    pull_all;
	wire [`GPIO_PIN_W-1:0]    digital_own;
	wire [`GPIO_PIN_W-1:0]    oe_next;
	wire [`GPIO_PIN_W-1:0]    out_next;
	wire [`GPIO_PIN_W-1:0]    ie_next;
	wire [`GPIO_PIN_W-1:0]    pullup_next;
	wire [`GPIO_PIN_W-1:0]    read_bits;
	wire                      do_write;
	wire                      write_ok;
	wire                      regs_frozen;
	wire [`GPIO_IDX_W-1:0]    w_idx;
	wire [`GPIO_IDX_W-1:0]    r_idx;
	reg  [`GPIO_DATA_W-1:0]   read_word;

	// ----------------------------------------------------------------
	// pin input synchroniser
	// ----------------------------------------------------------------
	pin_level_sync #(
		.WIDTH     (`GPIO_PIN_W)
	) u_pin_sync (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.raw_in    (pin_in),
		.level_out (pin_level)
	);

	// ----------------------------------------------------------------
	// per-pin control
	// ----------------------------------------------------------------
	assign data_all = {b_data_reg, a_data_reg};
	assign dir_all  = {b_dir_reg, a_dir_reg};
	// port A pin 4 has no pull-enable bit
	assign pull_all = {b_pull_reg, 1'b0, a_pull_reg};

	assign digital_own = alt_digital_en & ~alt_analog_en;

	assign oe_next  = deep_stop_mode ? `GPIO_PIN_RST :
		((digital_own & alt_digital_oe) |
		 (~alt_digital_en & ~alt_analog_en & dir_all));
	assign out_next = (digital_own & alt_digital_out) | (~digital_own & data_all);
	assign ie_next  = deep_stop_mode ? `GPIO_PIN_RST : ~alt_analog_en;
	assign pullup_next = deep_stop_mode ? `GPIO_PIN_RST :
		(pull_all & ~oe_next & ~alt_analog_en);

	// registered so pads never see glitches from the select logic
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_out       <= `GPIO_PIN_RST;
			pin_oe        <= `GPIO_PIN_RST;
			pin_ie        <= `GPIO_PIN_RST;
			pin_pullup_en <= `GPIO_PIN_RST;
		end else begin
			pin_out       <= out_next;
			pin_oe        <= oe_next;
			pin_ie        <= ie_next;
			pin_pullup_en <= pullup_next;
		end
	end

	// direction still chooses the read source under a digital function
	assign read_bits = port_read(data_all, dir_all, pin_ie, pin_level);

	// ----------------------------------------------------------------
	// write path
	// ----------------------------------------------------------------
	assign s_axi_awready = ~aw_held_reg;
	assign s_axi_wready  = ~w_held_reg;
	assign do_write      = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	assign w_idx         = aw_addr_reg[`GPIO_IDX_MSB:`GPIO_IDX_LSB];
	// stopped core cannot write; registers keep or lose state by mode
	assign regs_frozen   = deep_stop_mode | light_stop_mode;
	assign write_ok      = do_write & w_strb_reg[0] & ~regs_frozen;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg  <= 1'b0;
			aw_addr_reg  <= `GPIO_ADDR_RST;
			w_held_reg   <= 1'b0;
			w_data_reg   <= `GPIO_WORD_RST;
			w_strb_reg   <= `GPIO_STRB_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AXI_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_held_reg) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && !w_held_reg) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped_index(aw_addr_reg) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// port registers
	// ----------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn || deep_stop_mode) begin
			a_data_reg <= `GPIO_A_RST;
			a_pull_reg <= `GPIO_A_PULL_RST;
			a_dir_reg  <= `GPIO_A_RST;
			b_data_reg <= `GPIO_B_RST;
			b_pull_reg <= `GPIO_B_RST;
			b_dir_reg  <= `GPIO_B_RST;
		end else if (write_ok) begin
			// upper bits of the word are dropped here
			case (w_idx)
				`GPIO_IDX_A_DATA: begin
					a_data_reg <= w_data_reg[`GPIO_A_MSB:0];
				end
				`GPIO_IDX_A_PULL: begin
					a_pull_reg <= w_data_reg[`GPIO_A_PULL_MSB:0];
				end
				`GPIO_IDX_A_DIR: begin
					a_dir_reg <= w_data_reg[`GPIO_A_MSB:0];
				end
				`GPIO_IDX_B_DATA: begin
					b_data_reg <= w_data_reg[`GPIO_B_FLD_MSB:0];
				end
				`GPIO_IDX_B_PULL: begin
					b_pull_reg <= w_data_reg[`GPIO_B_FLD_MSB:0];
				end
				`GPIO_IDX_B_DIR: begin
					b_dir_reg <= w_data_reg[`GPIO_B_FLD_MSB:0];
				end
				default: begin
					a_data_reg <= a_data_reg;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;
	assign r_idx         = s_axi_araddr[`GPIO_IDX_MSB:`GPIO_IDX_LSB];

	always @* begin
		read_word = `GPIO_WORD_RST;
		case (r_idx)
			`GPIO_IDX_A_DATA: begin
				read_word[`GPIO_A_MSB:0] = read_bits[`GPIO_A_MSB:0];
			end
			`GPIO_IDX_A_PULL: begin
				read_word[`GPIO_A_PULL_MSB:0] = a_pull_reg;
			end
			`GPIO_IDX_A_DIR: begin
				read_word[`GPIO_A_MSB:0] = a_dir_reg;
			end
			`GPIO_IDX_B_DATA: begin
				read_word[`GPIO_B_FLD_MSB:0] = read_bits[`GPIO_B_MSB:`GPIO_B_LSB];
			end
			`GPIO_IDX_B_PULL: begin
				read_word[`GPIO_B_FLD_MSB:0] = b_pull_reg;
			end
			`GPIO_IDX_B_DIR: begin
				read_word[`GPIO_B_FLD_MSB:0] = b_dir_reg;
			end
			default: begin
				read_word = `GPIO_WORD_RST;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= `GPIO_WORD_RST;
			s_axi_rresp  <= `AXI_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= read_word;
			s_axi_rresp  <= mapped_index(s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// file: bench/gpio_pin_props.sv
// checker: pad relations of the port block seen at its ports
// assumes a bind into the port block, one clock domain
`timescale 1ns/100ps
`include "gpio_port_regs.vh"

module gpio_pin_props (
	// clock and reset
	input wire                    aclk,
	input wire                    aresetn,
	// read data
	input wire                    s_axi_rvalid,
	input wire [`GPIO_DATA_W-1:0] s_axi_rdata,
	// pads
	input wire [`GPIO_PIN_W-1:0]  pin_out,
	input wire [`GPIO_PIN_W-1:0]  pin_oe,
	input wire [`GPIO_PIN_W-1:0]  pin_ie,
	input wire [`GPIO_PIN_W-1:0]  pin_pullup_en,
	// shared functions and power
	input wire [`GPIO_PIN_W-1:0]  alt_digital_en,
	input wire [`GPIO_PIN_W-1:0]  alt_digital_oe,
	input wire [`GPIO_PIN_W-1:0]  alt_digital_out,
	input wire [`GPIO_PIN_W-1:0]  alt_analog_en,
	input wire                    deep_stop_mode
);
	// pins owned by a digital function, analog and deep stop win
	wire [`GPIO_PIN_W-1:0] dig_own = alt_digital_en & ~alt_analog_en & {7{~deep_stop_mode}};

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_analog_no_oe: assert property ((pin_oe & $past(alt_analog_en)) == 7'h00)
		else $error("pin driven under analog function");
	a_ie_source: assert property ($past(aresetn) |->
		pin_ie == ($past(deep_stop_mode) ? 7'h00 : ~$past(alt_analog_en)))
		else $error("input buffer enable wrong");
	a_pullup_vs_oe: assert property ((pin_pullup_en & pin_oe) == 7'h00)
		else $error("pullup on a driven pin");
	a_pin4_no_pull: assert property (!pin_pullup_en[4])
		else $error("pullup on pin without pull bit");
	a_pullup_analog: assert property ((pin_pullup_en & $past(alt_analog_en)) == 7'h00)
		else $error("pullup under analog function");
	a_deep_pins_off: assert property ($past(deep_stop_mode) |->
		(pin_oe | pin_ie | pin_pullup_en) == 7'h00)
		else $error("pad active in deep stop");
	a_digital_oe: assert property ($past(aresetn) |->
		((pin_oe ^ $past(alt_digital_oe)) & $past(dig_own)) == 7'h00)
		else $error("digital function lost output enable");
	a_digital_out: assert property ($past(aresetn) |->
		((pin_out ^ $past(alt_digital_out)) & $past(dig_own)) == 7'h00)
		else $error("digital function lost drive value");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0)
		else $error("unused read bits not zero");
endmodule

// file: bench/pin_pad_model.sv
// pad model: pin levels from design drivers, board sources and pullups
// assumes one clock; an undriven pad without pullup floats
`timescale 1ns/100ps

module pin_pad_model (
	// clock
	input  wire logic       aclk,
	// design side
	input  wire logic [6:0] pin_out,
	input  wire logic [6:0] pin_oe,
	input  wire logic [6:0] pin_pullup_en,
	// board side
	input  wire logic [6:0] ext_val,
	input  wire logic [6:0] ext_en,
	output wire logic [6:0] pin_in
);
	logic [6:0] float_reg = 7'h55;

	// a floating pad toggles so a steady guess never passes
	always @(posedge aclk)
		float_reg <= ~float_reg;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pin_pullup_en | float_reg));
endmodule

// file: bench/testbench.sv
// testbench: bus master, pad model and scenarios for the port block
// assumes the design, checker and pad model compiled before it
`timescale 1ns/100ps
`include "gpio_port_regs.vh"

module testbench;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	// response readies stay high all run, so no task ever lowers and raises them in one step
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
	logic        s_axi_arvalid = 0, s_axi_rready = 1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, d, dir, e;
	logic [6:0]  pin_in, pin_out, pin_oe, pin_ie, pin_pullup_en, ext_val = '0, ext_en = '0;
	logic [6:0]  alt_digital_en = '0, alt_digital_oe = '0, alt_digital_out = '0;
	logic [6:0]  alt_analog_en = '0;
	logic        deep_stop_mode = 0, light_stop_mode = 0;
	integer      n_errors = 0, total_checks = 0, seed = 32'h3163bda8;

	always #4 aclk = ~aclk;

	gpio_port_pin_control gpio_port_pin_control_i (.*);
	pin_pad_model pin_pad_model_i (.*);

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hang();
		n_errors++;
		$display("wrong value at %0t: no bus answer", $time);
		test_done();
	endtask
	// handshakes are judged before the edge, released by that edge;
	// a channel is dropped only once, at the edge that takes it
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		int n = 0;
		logic ta, tw, bv;
		bv = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!bv && n < 40) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			{bv, rs} = {s_axi_bvalid, s_axi_bresp};
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			n++;
		end
		if (!bv)
			hang();
	endtask
	task automatic rdr(input logic [11:0] a);
		int n = 0;
		logic ta, rv;
		rv = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!rv && n < 40) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			{rv, rd, rs} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'b0;
			n++;
		end
		if (!rv)
			hang();
	endtask
	task automatic pins(input logic [6:0] oe, pu, ie, out, om);
		@(negedge aclk);
		chk(pin_oe, oe);
		chk(pin_pullup_en, pu);
		chk(pin_ie, ie);
		chk(pin_out & om, out & om);
		@(posedge aclk);
	endtask
	function automatic logic [31:0] exp_rd(input logic [31:0] v, m, x);
		return {27'h0, (m[4:0] & v[4:0]) | (~m[4:0] & x[4:0])};
	endfunction

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		pins(7'h00, 7'h00, 7'h7f, 7'h00, 7'h7f);
		rdr(12'h000);
		chk(rd, 32'h0);
		wr(12'h004, 32'hff);
		rdr(12'h004);
		chk(rd, 32'h0f);
		$display("test reset and pull field finished");
		// data first, then direction, so no stale value is driven
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			dir = (i == 0) ? 32'h0 : (i == 1) ? 32'h1f : $random(seed);
			e = $random(seed);
			ext_val <= e[6:0];
			ext_en <= ~dir[6:0];
			wr(12'h000, d);
			wr(12'h00c, dir);
			pins(dir[6:0] & 7'h1f, {3'h0, ~dir[3:0]}, 7'h7f, d[6:0], 7'h1f);
			repeat (8) @(posedge aclk);
			rdr(12'h000);
			chk(rd, exp_rd(d, dir, e));
		end
		$display("test random direction and data finished");
		wr(12'h000, 32'h1f);
		wr(12'h00c, 32'h0a);
		alt_digital_en <= 7'h7f;
		alt_digital_oe <= 7'h7f;
		alt_analog_en <= 7'h7f;
		repeat (2) @(posedge aclk);
		pins(7'h00, 7'h00, 7'h00, 7'h1f, 7'h7f);
		rdr(12'h000);
		chk(rd, 32'h0a);
		alt_analog_en <= 7'h00;
		alt_digital_oe <= 7'h55;
		alt_digital_out <= 7'h33;
		repeat (2) @(posedge aclk);
		pins(7'h55, 7'h0a, 7'h7f, 7'h33, 7'h7f);
		rdr(12'h000);
		chk(rd & 32'h0a, 32'h0a);
		alt_digital_en <= 7'h00;
		$display("test shared functions finished");
		light_stop_mode <= 1'b1;
		wr(12'h000, 32'h00);
		chk(rs, `AXI_RESP_OKAY);
		pins(7'h0a, 7'h05, 7'h7f, 7'h1f, 7'h1f);
		rdr(12'h000);
		chk(rd & 32'h0a, 32'h0a);
		light_stop_mode <= 1'b0;
		deep_stop_mode <= 1'b1;
		repeat (3) @(posedge aclk);
		pins(7'h00, 7'h00, 7'h00, 7'h00, 7'h7f);
		deep_stop_mode <= 1'b0;
		@(posedge aclk);
		rdr(12'h00c);
		chk(rd, 32'h0);
		rdr(12'h004);
		chk(rd, 32'h0);
		$display("test stop modes finished");
		wr(12'h010, 32'h3);
		wr(12'h01c, 32'h3);
		pins(7'h60, 7'h00, 7'h7f, 7'h60, 7'h60);
		wr(12'h014, 32'h3);
		pins(7'h60, 7'h00, 7'h7f, 7'h60, 7'h7f);
		rdr(12'h010);
		chk(rd, 32'h3);
		wr(12'h3f0, 32'hff);
		chk(rs, `AXI_RESP_SLVERR);
		rdr(12'h3f0);
		chk(rs, `AXI_RESP_SLVERR);
		chk(rd, 32'h0);
		$display("test port b and unmapped finished");
		test_done();
	end
endmodule

bind gpio_port_pin_control gpio_pin_props gpio_pin_props_i (
	.aclk            (aclk),
	.aresetn         (aresetn),
	.s_axi_rvalid    (s_axi_rvalid),
	.s_axi_rdata     (s_axi_rdata),
	.pin_out         (pin_out),
	.pin_oe          (pin_oe),
	.pin_ie          (pin_ie),
	.pin_pullup_en   (pin_pullup_en),
	.alt_digital_en  (alt_digital_en),
	.alt_digital_oe  (alt_digital_oe),
	.alt_digital_out (alt_digital_out),
	.alt_analog_en   (alt_analog_en),
	.deep_stop_mode  (deep_stop_mode)
);
